/* hdl/reset_wake_irq_option_ctrl.sv */
// reset-cause flags, sleep/wake control, interrupt flags/mask and option decode
// assumes core strobes are one-cycle pulses on clk_i; pins and option strap are asynchronous
`timescale 1ns/10ps
module reset_wake_irq_option_ctrl
    import sysctl_pkg::*;
(
    input  wire logic              clk_i,            // 250 MHz clock
    input  wire logic              reset_i,          // sync reset, high
    input  wire logic              por_i,            // power-on event, high
    input  wire logic              reset_pin_n_i,    // external reset pin, async, low
    input  wire logic              wdog_expire_i,    // watchdog expiry pulse
    input  wire logic              tick_counter_ovf_i, // timer overflow level, falls on event
    input  wire logic              ext_irq_pin_n_i,  // external irq pin, async
    input  wire logic [PORT_W-1:0] port_pins_i,      // first port pin levels, async
    input  wire logic [PORT_W-1:0] port_is_out_i,    // 1 = pin configured output
    input  wire logic              ext_irq_sel_i,    // pin 0 used as external irq
    input  core_ops_t              ops_i,            // instruction strobes
    input  wire logic [NSRC-1:0]   irq_flag_clr_i,   // clear flag bits by instruction
    input  wire logic              irq_mask_we_i,    // mask write strobe
    input  wire logic [NSRC-1:0]   irq_mask_wdata_i, // mask write data
    input  wire logic [OPT_W-1:0]  opt_word_i,       // option word strap
    output logic                   core_reset_o,     // hold core in reset
    output logic                   timeout_flag_o,   // time-out status flag
    output logic                   sleep_flag_o,     // sleep status flag
    output logic                   osc_run_o,        // oscillator running
    output logic                   wdog_clr_o,       // watchdog clear pulse
    output logic                   irq_global_o,     // global irq enable
    output logic [NSRC-1:0]        irq_flag_reg_o,   // interrupt flags
    output logic [NSRC-1:0]        irq_mask_reg_o,   // interrupt mask
    output logic                   vector_req_o,     // fetch from vector
    output logic [9:0]             vector_addr_o,    // vector address
    output logic                   resume_o,         // wake, continue next instr
    output opt_cfg_t               opt_cfg_o         // decoded option settings
);
    // ==========================================================
    // synchronisers
    // ==========================================================
    logic              rst_pin_s;
    logic              ext_pin_s;
    logic [PORT_W-1:0] port_s;
    logic [PORT_W+1:0] sync_in;
    logic [PORT_W+1:0] sync_out;
    opt_cfg_t          cfg_w;

    assign sync_in = {reset_pin_n_i, ext_irq_pin_n_i, port_pins_i};

    pin_sync #(
        .W (PORT_W + 2)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     (sync_in),
        .q_o     (sync_out)
    );

    assign rst_pin_s = sync_out[PORT_W+1];
    assign ext_pin_s = sync_out[PORT_W];
    assign port_s    = sync_out[PORT_W-1:0];

    // option word only reaches the decoder, never a program path
    option_decode u_opt (
        .opt_word_i (opt_word_i),
        .cfg_o      (cfg_w)
    );

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        pwr_state_t        pwr;
        logic              tflag;
        logic              pflag;
        logic              core_rst;
        logic              osc_run;
        logic              wdclr;
        logic              gie;
        logic [NSRC-1:0]   flags;
        logic [NSRC-1:0]   mask;
        logic              vreq;
        logic              resume;
        logic              rst_pin_prev;
        logic              ext_prev;
        logic              tick_prev;
        logic [PORT_W-1:0] port_ref;
        opt_cfg_t          cfg;
        logic [9:0]        vaddr;
    } ctl_state_t;

    ctl_state_t st_q, st_d;

    // pins that take part in change detection
    function automatic logic [PORT_W-1:0] pchg_enable(
        input logic [PORT_W-1:0] is_out,
        input logic              ext_sel
    );
        logic [PORT_W-1:0] en;
        en = ~is_out;
        if (ext_sel) begin
            en[EXT_PIN_IDX] = 1'b0;
        end
        return en;
    endfunction

    logic [PORT_W-1:0] pchg_en;
    logic              pin_rst_fall;
    logic              ext_fall;
    logic              tick_fall;
    logic              pchg_hit;
    logic [NSRC-1:0]   set_ev;
    logic              sleeping;
    logic [PORT_W-1:0] pin_diff;

    // per-pin compare, excluded pins never flag
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin_diff
        assign pin_diff[i] = (port_s[i] ^ st_q.port_ref[i]) & pchg_en[i];
    end

    always_comb begin
        pchg_en      = pchg_enable(port_is_out_i, ext_irq_sel_i);
        pin_rst_fall = st_q.rst_pin_prev & ~rst_pin_s;
        ext_fall     = st_q.ext_prev & ~ext_pin_s & ext_irq_sel_i;
        tick_fall    = st_q.tick_prev & ~tick_counter_ovf_i;
        pchg_hit     = |pin_diff;
        sleeping     = (st_q.pwr == ST_SLEEP);
        set_ev       = '0;
        // flags ignore mask and global enable
        set_ev[SRC_TICK] = tick_fall;
        set_ev[SRC_EXT]  = ext_fall;
        // port-change flag only latches when its mask allows it
        set_ev[SRC_PCHG] = pchg_hit & st_q.mask[SRC_PCHG];
    end

    always_comb begin
        st_d              = st_q;
        st_d.wdclr        = 1'b0;
        st_d.vreq         = 1'b0;
        st_d.resume       = 1'b0;
        st_d.core_rst     = 1'b0;
        st_d.rst_pin_prev = rst_pin_s;
        st_d.ext_prev     = ext_pin_s;
        st_d.tick_prev    = tick_counter_ovf_i;
        st_d.cfg          = cfg_w;

        if (ops_i.port_read) begin
            st_d.port_ref = port_s;
        end

        // set wins over clear
        st_d.flags = (st_q.flags & ~irq_flag_clr_i) | set_ev;

        if (irq_mask_we_i) begin
            st_d.mask = irq_mask_wdata_i;
        end

        if (ops_i.irq_global_on || ops_i.return_from_irq) begin
            st_d.gie = 1'b1;
        end else if (ops_i.irq_global_off) begin
            st_d.gie = 1'b0;
        end

        case (st_q.pwr)
            ST_RUN: begin
                if (ops_i.wdog_clear_op) begin
                    st_d.tflag = 1'b1;
                    st_d.pflag = 1'b1;
                    st_d.wdclr = 1'b1;
                end
                if (ops_i.halt_op) begin
                    st_d.tflag   = 1'b1;
                    st_d.pflag   = 1'b0;
                    st_d.wdclr   = 1'b1;
                    st_d.osc_run = 1'b0;
                    st_d.pwr     = ST_SLEEP;
                end
                if (st_q.gie && |(st_q.flags & st_q.mask)) begin
                    st_d.vreq = 1'b1;
                    st_d.gie  = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (pchg_hit && st_q.mask[SRC_PCHG]) begin
                    st_d.tflag   = 1'b1;
                    st_d.pflag   = 1'b0;
                    st_d.osc_run = 1'b1;
                    st_d.pwr     = ST_WAKE;
                end
            end
            ST_WAKE: begin
                st_d.pwr = ST_RUN;
                if (st_q.gie) begin
                    st_d.vreq = 1'b1;
                    st_d.gie  = 1'b0;
                end else begin
                    st_d.resume = 1'b1;
                end
            end
            default: begin
                st_d.pwr = ST_RUN;
            end
        endcase

        // resets override power state, status flags, enables and requests above; interrupt flag updates still apply
        if (pin_rst_fall) begin
            if (sleeping) begin
                st_d.tflag = 1'b1;
                st_d.pflag = 1'b0;
            end else begin
                st_d.tflag = st_q.tflag;
                st_d.pflag = st_q.pflag;
            end
        end
        if (wdog_expire_i && st_q.cfg.wdog_en) begin
            st_d.tflag = 1'b0;
            st_d.pflag = sleeping ? 1'b0 : st_q.pflag;
        end
        if (pin_rst_fall || (wdog_expire_i && st_q.cfg.wdog_en)) begin
            st_d.core_rst = 1'b1;
            st_d.pwr      = ST_RUN;
            st_d.osc_run  = 1'b1;
            st_d.gie      = 1'b0;
            st_d.mask     = MASK_RST;
            st_d.vreq     = 1'b0;
            st_d.resume   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || por_i) begin
            st_q              <= '0;
            st_q.tflag        <= 1'b1;
            st_q.pflag        <= 1'b1;
            st_q.core_rst     <= 1'b1;
            st_q.osc_run      <= 1'b1;
            st_q.rst_pin_prev <= 1'b1;
            st_q.ext_prev     <= 1'b1;
            st_q.mask         <= MASK_RST;
            st_q.pwr          <= ST_RUN;
            st_q.vaddr        <= IRQ_VECTOR;
        end else begin
            st_q <= st_d;
        end
    end

    assign core_reset_o   = st_q.core_rst;
    assign timeout_flag_o = st_q.tflag;
    assign sleep_flag_o   = st_q.pflag;
    assign osc_run_o      = st_q.osc_run;
    assign wdog_clr_o     = st_q.wdclr;
    assign irq_global_o   = st_q.gie;
    assign irq_flag_reg_o = st_q.flags;
    assign irq_mask_reg_o = st_q.mask;
    assign vector_req_o   = st_q.vreq;
    assign vector_addr_o  = st_q.vaddr;
    assign resume_o       = st_q.resume;
    assign opt_cfg_o      = st_q.cfg;
endmodule

/* inc/sysctl_pkg.sv */
// system control constants and carriers: reset cause flags, interrupt sources, option word decode
// assumes one 250 MHz clock; core signals are same-domain, pins are asynchronous
//
// Overview of operation
// - reset on power-on, pin pulse, watchdog expiry
// - power-on sets both status flags
// - pin reset keeps flags; from sleep 1,0
// - watchdog reset clears timeout; from sleep 0,0
// - pin-change wake sets timeout, clears sleep
// - watchdog clear sets both; sleep sets 1,0
// - two falling-edge interrupt sources plus port change
// - port pins flag change unless output/irq pin
// - enabled pin change wakes; vector if global on
// - flags set regardless of mask, except port change
// - request is flag AND mask
// - enabled interrupt fetches from vector address
// - enable/disable instructions drive global enable
// - return-from-irq sets global enable
// - oscillator mode decoded from type/range/drive bits
// - range bit matters only in crystal type
// - option bit 11 low enables watchdog
// - option bit 10 selects 2 or 4 periods
// - option bit 6 selects drive power
// - option word unreachable by running program
package sysctl_pkg;
    localparam int          PORT_W        = 8;
    localparam int          NSRC          = 3;
    localparam int          OPT_W         = 13;
    localparam logic [9:0]  IRQ_VECTOR    = 10'h008;
    // interrupt flag / mask bit positions, external irq pin index
    localparam int          SRC_TICK      = 0;
    localparam int          SRC_PCHG      = 1;
    localparam int          SRC_EXT       = 2;
    localparam int          EXT_PIN_IDX   = 0;
    // option word fields, mask reset value
    localparam int          OPT_OSC_KIND  = 12;
    localparam int          OPT_WDOG_OFF  = 11;
    localparam int          OPT_CYC4      = 10;
    localparam int          OPT_XTAL_RNG  = 8;
    localparam int          OPT_DRIVE     = 6;
    localparam logic [2:0]  MASK_RST      = 3'h0;

    typedef enum logic [1:0] {
        rc_osc_mode    = 2'h0,
        xtal_fast_mode = 2'h1,
        xtal_slow_mode = 2'h2,
        osc_invalid    = 2'h3
    } osc_mode_t;

    // core instruction strobes, one-cycle pulses
    typedef struct packed {
        logic irq_global_on;
        logic irq_global_off;
        logic return_from_irq;
        logic wdog_clear_op;
        logic halt_op;
        logic port_read;
    } core_ops_t;

    typedef struct packed {
        osc_mode_t osc_mode;
        logic      wdog_en;
        logic      cyc4;
        logic      drive_high;
    } opt_cfg_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE  = 2'h3
    } pwr_state_t;
endpackage

/* hdl/pin_sync.sv */
// two-flop synchroniser bank for asynchronous pins
// assumes inputs are unrelated to clk_i
`timescale 1ns/10ps
module pin_sync
    import sysctl_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_i,   // system clock
    input  wire logic         reset_i, // sync reset, high
    input  wire logic [W-1:0] d_i,     // async level
    output logic      [W-1:0] q_o      // synchronised level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;
    sync_state_t st_q, st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            // pins idle high; a low reset value would fake a falling edge
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule

/* hdl/option_decode.sv */
// decodes the one-time option word into oscillator and watchdog settings
// assumes option word is a static strap, not reachable by the program
`timescale 1ns/10ps
module option_decode
    import sysctl_pkg::*;
(
    input  wire logic [OPT_W-1:0] opt_word_i, // programmed option word
    output opt_cfg_t              cfg_o       // decoded settings
);
    always_comb begin
        if (!opt_word_i[OPT_OSC_KIND]) begin
            cfg_o.osc_mode = rc_osc_mode;
        end else if (opt_word_i[OPT_XTAL_RNG]) begin
            cfg_o.osc_mode = xtal_fast_mode;
        end else if (!opt_word_i[OPT_DRIVE]) begin
            cfg_o.osc_mode = xtal_slow_mode;
        end else begin
            cfg_o.osc_mode = osc_invalid;
        end
        cfg_o.wdog_en    = ~opt_word_i[OPT_WDOG_OFF];
        cfg_o.cyc4       = opt_word_i[OPT_CYC4];
        cfg_o.drive_high = opt_word_i[OPT_DRIVE];
    end
endmodule

/* bench/sysctl_chk_asserts.sv */
// port checker for the system control block
// assumes bind to the top module, one clock, one-cycle strobes
`timescale 1ns/10ps
module sysctl_chk
    import sysctl_pkg::*;
(
    input wire logic             clk_i,              // clk
    input wire logic             reset_i,            // rst
    input wire logic             por_i,              // por
    input wire logic             wdog_expire_i,      // wdog
    input wire logic             tick_counter_ovf_i, // timer
    input core_ops_t             ops_i,              // ops
    input wire logic [OPT_W-1:0] opt_word_i,         // option
    input wire logic             timeout_flag_o,     // t
    input wire logic             sleep_flag_o,       // p
    input wire logic             osc_run_o,          // osc
    input wire logic             wdog_clr_o,         // clr
    input wire logic             irq_global_o,       // gie
    input wire logic [NSRC-1:0]  irq_flag_reg_o,     // flags
    input wire logic [NSRC-1:0]  irq_mask_reg_o,     // mask
    input wire logic             vector_req_o,       // vec
    input wire logic [9:0]       vector_addr_o,      // addr
    input wire logic             resume_o,           // resume
    input wire logic             core_reset_o,       // core rst
    input opt_cfg_t              opt_cfg_o           // cfg
);
    logic       rst;
    logic [1:0] osc_exp;
    logic [2:0] op_ok;
    assign rst = reset_i || por_i;
    assign osc_exp = !opt_word_i[OPT_OSC_KIND] ? 2'h0 : opt_word_i[OPT_XTAL_RNG] ? 2'h1 : opt_word_i[OPT_DRIVE] ? 2'h3 : 2'h2;
    assign op_ok = {ops_i == '0, !wdog_expire_i, !opt_word_i[OPT_WDOG_OFF]};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst);
    // ====
    // properties
    AST_OSC: assert property (!$past(rst) |-> opt_cfg_o.osc_mode == $past(osc_exp))
        else $error("osc mode decode wrong");
    AST_OPT: assert property (!$past(rst) |-> {opt_cfg_o.wdog_en, opt_cfg_o.cyc4, opt_cfg_o.drive_high} ==
        {!$past(opt_word_i[OPT_WDOG_OFF]), $past(opt_word_i[OPT_CYC4]), $past(opt_word_i[OPT_DRIVE])})
        else $error("option bits decode wrong");
    AST_WDC: assert property (ops_i.wdog_clear_op && op_ok[1] |=> timeout_flag_o && sleep_flag_o && wdog_clr_o)
        else $error("wdog clear flags wrong");
    AST_HALT: assert property (ops_i.halt_op && osc_run_o && op_ok[1] |=>
        timeout_flag_o && !sleep_flag_o && !osc_run_o && wdog_clr_o)
        else $error("halt flags wrong");
    AST_GON: assert property ((ops_i.irq_global_on || ops_i.return_from_irq) && !irq_global_o |=> irq_global_o)
        else $error("global enable not set");
    AST_GOFF: assert property (ops_i.irq_global_off |=> !irq_global_o)
        else $error("global enable not cleared");
    AST_VEC: assert property (vector_req_o |-> $past(irq_global_o && (irq_flag_reg_o & irq_mask_reg_o) != '0)
        && vector_addr_o == IRQ_VECTOR)
        else $error("vector without enabled request");
    AST_RES: assert property (resume_o |-> !irq_global_o && osc_run_o && timeout_flag_o && !sleep_flag_o)
        else $error("resume state wrong");
    AST_TICK: assert property (!$past(rst) && $fell(tick_counter_ovf_i) |-> ##[1:2] irq_flag_reg_o[SRC_TICK])
        else $error("timer flag not set");
    AST_WDR: assert property (wdog_expire_i && op_ok[0] && osc_run_o && op_ok[2] |=>
        !timeout_flag_o && sleep_flag_o == $past(sleep_flag_o))
        else $error("wdog reset flags wrong");
    AST_WDOFF: assert property (wdog_expire_i && !op_ok[0] && op_ok[2] |=> !core_reset_o && $stable(timeout_flag_o))
        else $error("disabled wdog acted");
    COV_VEC: cover property (vector_req_o);
    COV_RES: cover property (resume_o);
    COV_RST: cover property (core_reset_o && !reset_i);
endmodule

bind reset_wake_irq_option_ctrl sysctl_chk sysctl_chk_inst (.*);

/* bench/core_model.sv */
// behavioural core: mask writes and interrupt service
// assumes strobes launched on the rising edge
`timescale 1ns/10ps
module core_model
    import sysctl_pkg::*;
(
    input  wire logic            clk_i,            // clk
    input  wire logic            reset_i,          // rst
    input  wire logic            vec_i,            // vector fetch
    input  wire logic [NSRC-1:0] flags_i,          // flags
    input  wire logic [NSRC-1:0] mask_i,           // mask
    input  wire logic            wr_req_i,         // mask write wanted
    input  wire logic [NSRC-1:0] wr_val_i,         // mask value
    input  wire logic [3:0]      lag_i,            // service delay
    output core_ops_t            ops_o = '0,       // strobes
    output logic      [NSRC-1:0] clr_o = '0,       // flag clear
    output logic                 we_o = 1'b0,      // mask write
    output logic      [NSRC-1:0] wdata_o = '0      // mask data
);
    logic       wr_q;
    logic [4:0] isr_q;
    always @(posedge clk_i) begin
        // read before mask, clear before return
        ops_o <= core_ops_t'({2'h0, !reset_i && isr_q == 5'h1, 2'h0, !reset_i && wr_req_i});
        clr_o <= (!reset_i && isr_q == 5'h2) ? (flags_i & mask_i) : '0;
        we_o  <= !reset_i && wr_q;
        wr_q  <= !reset_i && wr_req_i;
        if (wr_req_i)
            wdata_o <= wr_val_i;
        if (reset_i)
            isr_q <= '0;
        else if (vec_i)
            isr_q <= {1'b0, lag_i} + 5'h2;
        else if (isr_q != '0)
            isr_q <= isr_q - 5'h1;
    end
endmodule

/* bench/reset_wake_irq_option_ctrl_tb.sv */
// testbench for the system control block
// assumes core_model stands for the core; pins driven as async levels
`timescale 1ns/10ps
module reset_wake_irq_option_ctrl_tb
    import sysctl_pkg::*;
;
    localparam core_ops_t OP_ON = 6'h20, OP_OFF = 6'h10, OP_WDC = 6'h04, OP_HALT = 6'h02;
    logic              clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b0, reset_pin_n_i = 1'b1, wdog_expire_i = 1'b0;
    logic              tick_counter_ovf_i = 1'b1, ext_irq_pin_n_i = 1'b1, ext_irq_sel_i = 1'b0, mreq = 1'b0;
    logic              irq_mask_we_i, core_reset_o, timeout_flag_o, sleep_flag_o, osc_run_o;
    logic              wdog_clr_o, irq_global_o, vector_req_o, resume_o;
    logic [PORT_W-1:0] port_pins_i = 8'h00, port_is_out_i = 8'h00;
    logic [NSRC-1:0]   irq_flag_clr_i, irq_mask_wdata_i, irq_flag_reg_o, irq_mask_reg_o, mval = 3'h0;
    logic [OPT_W-1:0]  opt_word_i = 13'h0000;
    logic [9:0]        vector_addr_o;
    logic [3:0]        lag = 4'h0;
    core_ops_t         ops_i, tb_ops = '0, pm_ops;
    opt_cfg_t          opt_cfg_o;
    int                fail_count = 0;
    int                n_tests = 0;
    assign ops_i = core_ops_t'(tb_ops | pm_ops);
    always #2 clk_i = ~clk_i;
    reset_wake_irq_option_ctrl reset_wake_irq_option_ctrl_inst (.*);
    core_model core_model_inst (.clk_i(clk_i), .reset_i(reset_i || core_reset_o), .vec_i(vector_req_o),
        .flags_i(irq_flag_reg_o), .mask_i(irq_mask_reg_o), .wr_req_i(mreq), .wr_val_i(mval), .lag_i(lag),
        .ops_o(pm_ops), .clr_o(irq_flag_clr_i), .we_o(irq_mask_we_i), .wdata_o(irq_mask_wdata_i));
    // ====
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask
    task automatic step();
        @(posedge clk_i);
        tb_ops        <= '0;
        wdog_expire_i <= 1'b0;
        mreq          <= 1'b0;
        #1;
    endtask
    task automatic op(input core_ops_t v);
        @(posedge clk_i);
        tb_ops <= v;
        step();
    endtask
    task automatic kick();
        @(posedge clk_i);
        wdog_expire_i <= 1'b1;
        step();
    endtask
    task automatic set_mask(input logic [NSRC-1:0] v);
        @(posedge clk_i);
        mreq <= 1'b1;
        mval <= v;
        step();
    endtask
    // short waits: pulses are caught the cycle they stand
    task automatic wait_sig(input int k);
        for (int i = 0; i < 20; i++) begin
            if ((k == 0 && vector_req_o === 1'b1) || (k == 1 && resume_o === 1'b1) || (k == 2 && core_reset_o === 1'b1))
                return;
            @(posedge clk_i);
            #1;
        end
        check(1'b0, 1'b1, "no answer");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_opt();
        logic [OPT_W-1:0] w[5] = '{13'h0000, 13'h1D40, 13'h1000, 13'h1040, 13'h0500};
        foreach (w[i]) begin
            @(posedge clk_i);
            opt_word_i <= w[i];
            repeat (2) @(posedge clk_i);
            #1;
            check(opt_cfg_o.osc_mode, w[i][12] ? (w[i][8] ? 2'h1 : (w[i][6] ? 2'h3 : 2'h2)) : 2'h0, "osc");
            check(opt_cfg_o.wdog_en, !w[i][OPT_WDOG_OFF], "wdog en");
            check({opt_cfg_o.cyc4, opt_cfg_o.drive_high}, {w[i][OPT_CYC4], w[i][OPT_DRIVE]}, "cyc drive");
        end
        @(posedge clk_i);
        opt_word_i <= 13'h0000;
        $display("test opt done");
    endtask
    task automatic t_flags();
        op(OP_WDC);
        check({timeout_flag_o, sleep_flag_o, wdog_clr_o}, 3'h7, "wdog clear");
        op(OP_HALT);
        check({timeout_flag_o, sleep_flag_o, osc_run_o, wdog_clr_o}, 4'h9, "halt");
        kick();
        wait_sig(2);
        check({timeout_flag_o, sleep_flag_o}, 2'h0, "wdog in sleep");
        op(OP_WDC);
        kick();
        wait_sig(2);
        check({timeout_flag_o, sleep_flag_o}, 2'h1, "wdog run");
        @(posedge clk_i);
        reset_pin_n_i <= 1'b0;
        #1;
        wait_sig(2);
        check({timeout_flag_o, sleep_flag_o}, 2'h1, "pin reset");
        @(posedge clk_i);
        reset_pin_n_i <= 1'b1;
        opt_word_i    <= 13'h0800;
        op(OP_WDC);
        kick();
        repeat (4) step();
        check(timeout_flag_o, 1'b1, "wdog off");
        @(posedge clk_i);
        opt_word_i <= 13'h0000;
        kick();
        wait_sig(2);
        @(posedge clk_i);
        por_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        por_i <= 1'b0;
        step();
        check({timeout_flag_o, sleep_flag_o}, 2'h3, "power on");
        $display("test flags done");
    endtask
    task automatic t_wake();
        @(posedge clk_i);
        lag           <= 4'h3;
        port_is_out_i <= 8'h08;
        ext_irq_sel_i <= 1'b1;
        set_mask(3'h2);
        repeat (4) @(posedge clk_i);
        port_pins_i <= 8'h09;
        repeat (6) step();
        check(irq_flag_reg_o[SRC_PCHG], 1'b0, "excluded pins");
        // second pass sleeps with global enable on, so the wake must vector
        for (int k = 0; k < 2; k++) begin
            op(OP_HALT);
            @(posedge clk_i);
            port_pins_i <= 8'h29;
            #1;
            wait_sig(1 - k);
            check({timeout_flag_o, sleep_flag_o}, 2'h2, "pin wake");
            check({osc_run_o, irq_flag_reg_o[SRC_PCHG]}, 2'h3, "woke flag");
            check({resume_o, vector_req_o}, (k == 0) ? 2'h2 : 2'h1, "wake exit");
            @(posedge clk_i);
            port_pins_i <= 8'h09;
            if (k == 0) begin
                op(OP_ON);
                wait_sig(0);
            end
            check(vector_addr_o, IRQ_VECTOR, "vector");
            repeat (10) step();
            check({irq_global_o, irq_flag_reg_o}, 4'h8, "isr return");
        end
        $display("test wake done");
    endtask
    task automatic t_irq();
        lag <= 4'h0;
        @(posedge clk_i);
        tick_counter_ovf_i <= 1'b0;
        ext_irq_pin_n_i    <= 1'b0;
        repeat (5) step();
        check({irq_global_o, irq_flag_reg_o}, 4'hD, "flags unmasked");
        @(posedge clk_i);
        tick_counter_ovf_i <= 1'b1;
        ext_irq_pin_n_i    <= 1'b1;
        set_mask(3'h5);
        wait_sig(0);
        repeat (6) step();
        check({irq_global_o, irq_mask_reg_o, irq_flag_reg_o}, 7'h68, "masked service");
        op(OP_OFF);
        check(irq_global_o, 1'b0, "global off");
        $display("test irq done");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        check({timeout_flag_o, sleep_flag_o, core_reset_o, irq_global_o}, 4'hE, "reset");
        @(posedge clk_i);
        reset_i <= 1'b0;
        t_opt();
        t_flags();
        t_wake();
        t_irq();
        final_report();
    end
    initial begin
        #40000;
        fail_count++;
        final_report();
    end
endmodule
